// ---- rtl/ilo_decode_map.svh ----
// Constants for the indexed literal offset address decoder
`ifndef ILO_DECODE_MAP_SVH
`define ILO_DECODE_MAP_SVH
`define ILO_OFFSET_MAX      8'h5F
`define ILO_ADDR_W          12
`define ILO_ACCESS_SPLIT    8'h60
`define ILO_ACCESS_HI_BANK  4'hF
`define ILO_ALL_ONES        8'hFF
`define ILO_OP_ADD_HI       6'h09
`define ILO_OP_BITSET_HI    4'h8
`define ILO_OP_SETALL_HI    7'h34
`define ILO_ACCESS_BIT      8
`define ILO_DEST_BIT        9
`endif

// ---- rtl/ilo_decode_pkg.sv ----
// Types for the indexed literal offset address decoder
`default_nettype none
package ilo_decode_pkg;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_ADD,
    OP_BITSET,
    OP_SETALL
  } op_kind_e;
  typedef logic [11:0] data_addr_t;
endpackage : ilo_decode_pkg
`default_nettype wire

// ---- rtl/indexed_literal_offset_decode.sv ----
// Operand address decode and execute for add, bit-set and set-all-ones
// Operation
// - Extension off: operand is Access Bank address (a=0) or in the bank_select_register bank (a=1).
// - Extension on, a=0, operand <= 5Fh: address is stack_frame_pointer plus offset 0..95.
// - Operands above 5Fh keep literal addressing even with the extension on.
// - Offset interpretation applies to every byte and bit instruction with the access bit.
// - With a zero pointer, indexed addresses equal the Access Bank addresses.
// - Destination bit 0 sends the result to the accumulator, 1 back to the register.
// - Indexed add sums accumulator and byte, routes by destination, updates N, OV, C, DC, Z.
// - Indexed bit-set sets bit b of the byte and leaves flags alone.
// - Indexed set-all-ones writes FFh, no flag change, one word and one cycle.
// - Indexed mode is only reached with the encoded access bit 0.
// - A configuration bit at 0 disables the extension; 1 enables it.
// - Effective address may lie anywhere in the 4096-byte space.
`timescale 1ns/100ps
`default_nettype none
`include "ilo_decode_map.svh"
module indexed_literal_offset_decode #(
  parameter int ADDR_W = `ILO_ADDR_W
) (
  // Clock, reset, enable
  input  wire logic                      ref_clk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic                      clk_en_in,
  // Configuration and pointers
  input  wire logic                      extension_enable_config_in,
  input  wire logic [7:0]                bank_select_register_in,
  input  wire logic [11:0]               stack_frame_pointer_in,
  // Instruction and operands
  input  wire logic                      instr_valid_in,
  input  wire logic [15:0]               instr_word_in,
  input  wire logic [7:0]                accumulator_in,
  input  wire logic [7:0]                file_rdata_in,
  // Combinational read address to data memory
  output logic [11:0]                    file_raddr_out,
  // Results
  output logic                           file_we_out,
  output ilo_decode_pkg::data_addr_t     file_waddr_out,
  output logic [7:0]                     file_wdata_out,
  output logic                           acc_we_out,
  output logic [7:0]                     acc_wdata_out,
  output logic                           flags_we_out,
  output logic [4:0]                     flags_out,
  output logic                           extension_active_out
);
  import ilo_decode_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Effective address of a byte or bit operand
  // Used by the read port only; the write address copies it and the checks recompute the decode themselves
  function automatic data_addr_t eff_addr(input logic ext, input logic a, input logic [7:0] f,
                                          input logic [7:0] bank_select_register, input logic [11:0] fp);
    data_addr_t r;
    r = 12'h000;
    if (ext && !a && f <= `ILO_OFFSET_MAX) begin
      r = fp + {4'h0, f};
    end else if (a) begin
      r = {bank_select_register[3:0], f};
    end else if (f < `ILO_ACCESS_SPLIT) begin
      r = {4'h0, f};
    end else begin
      r = {`ILO_ACCESS_HI_BANK, f};
    end
    return r;
  endfunction : eff_addr

  logic        ext_cfg, next_ext_cfg;
  logic        cfg_taken, next_cfg_taken;
  logic        next_file_we, next_acc_we, next_flags_we;
  logic [11:0] next_waddr;
  logic [7:0]  next_wdata, next_acc;
  logic [4:0]  next_flags;
  op_kind_e    kind;
  logic [8:0]  sum;
  logic [4:0]  nib;
  logic [7:0]  res;

  // ----------------------------------------
  // Configuration capture
  // ----------------------------------------
  // Static capture of the extension configuration
  // Taken once so a late change on the pin cannot remap live operands
  always_comb begin
    next_ext_cfg   = ext_cfg;
    next_cfg_taken = cfg_taken;
    if (!cfg_taken) begin
      next_ext_cfg   = extension_enable_config_in;
      next_cfg_taken = 1'b1;
    end
  end

  assign file_raddr_out = eff_addr(ext_cfg, instr_word_in[`ILO_ACCESS_BIT], instr_word_in[7:0],
                                   bank_select_register_in, stack_frame_pointer_in);

  // ----------------------------------------
  // Execute
  // ----------------------------------------
  // Opcode classification and single-cycle execution
  // Unknown opcodes fall to the default branch and raise no strobe
  always_comb begin
    kind = OP_NONE;
    if (instr_word_in[15:10] == `ILO_OP_ADD_HI) kind = OP_ADD;
    else if (instr_word_in[15:12] == `ILO_OP_BITSET_HI) kind = OP_BITSET;
    else if (instr_word_in[15:9] == `ILO_OP_SETALL_HI) kind = OP_SETALL;
    sum = {1'b0, accumulator_in} + {1'b0, file_rdata_in};
    nib = {1'b0, accumulator_in[3:0]} + {1'b0, file_rdata_in[3:0]};
    res = 8'h00;
    next_file_we  = 1'b0;
    next_acc_we   = 1'b0;
    next_flags_we = 1'b0;
    next_flags    = flags_out;
    next_acc      = acc_wdata_out;
    next_waddr    = file_raddr_out;
    next_wdata    = file_wdata_out;
    if (instr_valid_in) begin
      case (kind)
        OP_ADD: begin
          res           = sum[7:0];
          next_flags_we = 1'b1;
          next_flags    = {res[7], (accumulator_in[7] == file_rdata_in[7]) &&
                           (res[7] != accumulator_in[7]), sum[8], nib[4], res == 8'h00};
          if (instr_word_in[`ILO_DEST_BIT]) begin
            next_file_we = 1'b1;
            next_wdata   = res;
          end else begin
            next_acc_we = 1'b1;
            next_acc    = res;
          end
        end
        OP_BITSET: begin
          next_file_we = 1'b1;
          next_wdata   = file_rdata_in | (8'h01 << instr_word_in[11:9]);
        end
        OP_SETALL: begin
          next_file_we = 1'b1;
          next_wdata   = `ILO_ALL_ONES;
        end
        default: begin
          next_file_we = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // State registers; clock enable low holds every one, outputs included
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ext_cfg              <= 1'b0;
      cfg_taken            <= 1'b0;
      file_we_out          <= 1'b0;
      file_waddr_out       <= 12'h000;
      file_wdata_out       <= 8'h00;
      acc_we_out           <= 1'b0;
      acc_wdata_out        <= 8'h00;
      flags_we_out         <= 1'b0;
      flags_out            <= 5'h00;
      extension_active_out <= 1'b0;
    end else if (clk_en_in) begin
      ext_cfg              <= next_ext_cfg;
      cfg_taken            <= next_cfg_taken;
      file_we_out          <= next_file_we;
      file_waddr_out       <= next_waddr;
      file_wdata_out       <= next_wdata;
      acc_we_out           <= next_acc_we;
      acc_wdata_out        <= next_acc;
      flags_we_out         <= next_flags_we;
      flags_out            <= next_flags;
      extension_active_out <= next_ext_cfg;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Configuration stays put once it has been captured
  a_cfg_static: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    cfg_taken |=> $stable(ext_cfg)) else $error("config changed");

  // Indexed operand resolves to pointer plus offset
  a_index_addr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ext_cfg && !instr_word_in[`ILO_ACCESS_BIT] && instr_word_in[7:0] <= `ILO_OFFSET_MAX |->
    file_raddr_out == stack_frame_pointer_in + {4'h0, instr_word_in[7:0]})
    else $error("indexed address wrong");

  // Upper operands stay literal in the high access half
  a_lit_high: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !instr_word_in[`ILO_ACCESS_BIT] && instr_word_in[7:0] > `ILO_OFFSET_MAX |->
    file_raddr_out == {`ILO_ACCESS_HI_BANK, instr_word_in[7:0]})
    else $error("high literal wrong");

  // Extension off keeps the lower access half literal
  a_lit_low: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !ext_cfg && !instr_word_in[`ILO_ACCESS_BIT] && instr_word_in[7:0] < `ILO_ACCESS_SPLIT |->
    file_raddr_out == {4'h0, instr_word_in[7:0]}) else $error("low literal wrong");

  // Banked operand takes the bank from the select register
  a_bank_addr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    instr_word_in[`ILO_ACCESS_BIT] |->
    file_raddr_out == {bank_select_register_in[3:0], instr_word_in[7:0]})
    else $error("banked address wrong");

  // A zero pointer lands on the plain access addresses
  a_zero_ptr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    stack_frame_pointer_in == 12'h000 && !instr_word_in[`ILO_ACCESS_BIT] &&
    instr_word_in[7:0] <= `ILO_OFFSET_MAX |->
    file_raddr_out == {4'h0, instr_word_in[7:0]}) else $error("zero pointer mismatch");

  // Set-all-ones writes the full byte and leaves flags alone
  a_setall_ones: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    clk_en_in && instr_valid_in && kind == OP_SETALL |=>
    file_we_out && file_wdata_out == `ILO_ALL_ONES && !flags_we_out)
    else $error("set-all wrong");

  // Bit-set raises the chosen bit and leaves flags alone
  a_bitset_flags: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    clk_en_in && instr_valid_in && kind == OP_BITSET |=>
    file_we_out && !flags_we_out && file_wdata_out[$past(instr_word_in[11:9])])
    else $error("bit-set wrong");

  // Add routes its result by the destination bit and updates flags
  a_add_dest: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    clk_en_in && instr_valid_in && kind == OP_ADD |=>
    flags_we_out && (file_we_out == $past(instr_word_in[`ILO_DEST_BIT])) &&
    (acc_we_out != file_we_out)) else $error("add routing wrong");

  // Add written back to the file carries the 8-bit sum
  a_add_sum: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    clk_en_in && instr_valid_in && kind == OP_ADD && instr_word_in[`ILO_DEST_BIT] |=>
    file_wdata_out == 8'($past(accumulator_in) + $past(file_rdata_in)))
    else $error("add sum wrong");

  // Idle cycles and unknown opcodes raise no strobe
  a_no_strobe: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    clk_en_in && (!instr_valid_in || kind == OP_NONE) |=>
    !file_we_out && !acc_we_out && !flags_we_out) else $error("stray strobe");

  // Clock enable low freezes results and configuration
  a_frozen_hold: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !clk_en_in |=> $stable(file_we_out) && $stable(file_wdata_out) && $stable(acc_we_out) &&
    $stable(flags_we_out) && $stable(ext_cfg)) else $error("frozen state moved");
endmodule : indexed_literal_offset_decode
`default_nettype wire

// ---- tb/indexed_literal_offset_decode_test.sv ----
// Directed testbench for the indexed literal offset address decoder
`timescale 1ns/100ps
`default_nettype none
module indexed_literal_offset_decode_test;
  import ilo_decode_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        ref_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        clk_en_in = 1'b1;
  logic        extension_enable_config_in = 1'b0;
  logic [7:0]  bank_select_register_in = 8'h00;
  logic [11:0] stack_frame_pointer_in = 12'h000;
  logic        instr_valid_in = 1'b0;
  logic [15:0] instr_word_in = 16'h0000;
  logic [7:0]  accumulator_in = 8'h00;
  logic [7:0]  file_rdata_in = 8'h00;
  logic [11:0] file_raddr_out;
  logic        file_we_out;
  data_addr_t  file_waddr_out;
  logic [7:0]  file_wdata_out;
  logic        acc_we_out;
  logic [7:0]  acc_wdata_out;
  logic        flags_we_out;
  logic [4:0]  flags_out;
  logic        extension_active_out;
  int          err_count = 0;
  int          n_compared = 0;
  // 250 MHz clock
  always #2 ref_clk_in = ~ref_clk_in;
  indexed_literal_offset_decode indexed_literal_offset_decode_i (
    .ref_clk_in                 (ref_clk_in),
    .sys_rst_in                 (sys_rst_in),
    .clk_en_in                  (clk_en_in),
    .extension_enable_config_in (extension_enable_config_in),
    .bank_select_register_in    (bank_select_register_in),
    .stack_frame_pointer_in     (stack_frame_pointer_in),
    .instr_valid_in             (instr_valid_in),
    .instr_word_in              (instr_word_in),
    .accumulator_in             (accumulator_in),
    .file_rdata_in              (file_rdata_in),
    .file_raddr_out             (file_raddr_out),
    .file_we_out                (file_we_out),
    .file_waddr_out             (file_waddr_out),
    .file_wdata_out             (file_wdata_out),
    .acc_we_out                 (acc_we_out),
    .acc_wdata_out              (acc_wdata_out),
    .flags_we_out               (flags_we_out),
    .flags_out                  (flags_out),
    .extension_active_out       (extension_active_out)
  );
  // ----------------------------------------
  // Compare tasks
  // ----------------------------------------
  task automatic chk_addr(input string what, input logic [11:0] e, input logic [11:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk_addr
  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk_byte
  task automatic chk_bit(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  // Synchronous reset for 3 cycles, then let the configuration capture edge pass
  task automatic do_reset(input logic cfg);
    extension_enable_config_in = cfg;
    sys_rst_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    @(negedge ref_clk_in);
  endtask : do_reset
  // One instruction for one cycle; the read address is combinational
  task automatic issue(input logic [15:0] w, input logic [7:0] a, input logic [7:0] r,
                       input logic [11:0] ra);
    @(negedge ref_clk_in);
    instr_valid_in = 1'b1;
    instr_word_in = w;
    accumulator_in = a;
    file_rdata_in = r;
    #1;
    chk_addr("read address", ra, file_raddr_out);
    @(negedge ref_clk_in);
    instr_valid_in = 1'b0;
  endtask : issue
  // Results one cycle after the instruction was taken
  task automatic expect_out(input logic fw, input logic [11:0] wa, input logic [7:0] wd,
                            input logic aw, input logic [7:0] ad, input logic lw,
                            input logic [4:0] fl);
    chk_bit("file write", fw, file_we_out);
    if (fw) chk_addr("write address", wa, file_waddr_out);
    if (fw) chk_byte("write data", wd, file_wdata_out);
    chk_bit("acc write", aw, acc_we_out);
    if (aw) chk_byte("acc data", ad, acc_wdata_out);
    chk_bit("flags write", lw, flags_we_out);
    if (lw) chk_byte("flags", {3'h0, fl}, {3'h0, flags_out});
  endtask : expect_out
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    do_reset(1'b0);
    chk_bit("extension active", 1'b0, extension_active_out);
    stack_frame_pointer_in = 12'hA00;
    bank_select_register_in = 8'h05;
    issue(16'h6820, 8'h00, 8'h00, 12'h020);
    issue(16'h6860, 8'h00, 8'h00, 12'hF60);
    issue(16'h6920, 8'h00, 8'h00, 12'h520);
    $display("test literal addressing done");
    do_reset(1'b1);
    chk_bit("extension active", 1'b1, extension_active_out);
    issue(16'h6820, 8'h00, 8'h00, 12'hA20);
    issue(16'h685F, 8'h00, 8'h00, 12'hA5F);
    issue(16'h6860, 8'h00, 8'h00, 12'hF60);
    issue(16'h6920, 8'h00, 8'h00, 12'h520);
    stack_frame_pointer_in = 12'h000;
    issue(16'h682C, 8'h00, 8'h00, 12'h02C);
    stack_frame_pointer_in = 12'hFFF;
    issue(16'h685F, 8'h00, 8'h00, 12'h05E);
    $display("test indexed addressing done");
    stack_frame_pointer_in = 12'hA00;
    issue(16'h262C, 8'h17, 8'h20, 12'hA2C);
    expect_out(1'b1, 12'hA2C, 8'h37, 1'b0, 8'h00, 1'b1, 5'h00);
    issue(16'h242C, 8'hFF, 8'h01, 12'hA2C);
    expect_out(1'b0, 12'h000, 8'h00, 1'b1, 8'h00, 1'b1, 5'h07);
    issue(16'h262C, 8'h7F, 8'h01, 12'hA2C);
    expect_out(1'b1, 12'hA2C, 8'h80, 1'b0, 8'h00, 1'b1, 5'h1A);
    issue(16'h8E0A, 8'h00, 8'h55, 12'hA0A);
    expect_out(1'b1, 12'hA0A, 8'hD5, 1'b0, 8'h00, 1'b0, 5'h00);
    issue(16'h682C, 8'h00, 8'h00, 12'hA2C);
    expect_out(1'b1, 12'hA2C, 8'hFF, 1'b0, 8'h00, 1'b0, 5'h00);
    issue(16'h0E2C, 8'h17, 8'h20, 12'hA2C);
    expect_out(1'b0, 12'h000, 8'h00, 1'b0, 8'h00, 1'b0, 5'h00);
    $display("test execute done");
    extension_enable_config_in = 1'b0;
    issue(16'h6820, 8'h00, 8'h00, 12'hA20);
    chk_bit("extension active", 1'b1, extension_active_out);
    clk_en_in = 1'b0;
    issue(16'h242C, 8'h01, 8'h01, 12'hA2C);
    chk_bit("file write held", 1'b1, file_we_out);
    chk_bit("acc write frozen", 1'b0, acc_we_out);
    clk_en_in = 1'b1;
    @(negedge ref_clk_in);
    chk_bit("file write ended", 1'b0, file_we_out);
    chk_bit("acc write not taken", 1'b0, acc_we_out);
    $display("test static config done");
    end_sim();
  end
endmodule : indexed_literal_offset_decode_test
`default_nettype wire
